/* File: hw/pcgc_regs.sv */
`include "pcgc_map.svh"
`timescale 1ns/100ps
`default_nettype none
module pcgc_regs #(
   parameter int           NUM_CTR      = 4,
   parameter bit           ID_IMPL      = 1'b1,
   parameter logic [11:0]  ID_PART      = 12'h123, // arbitrary value
   parameter logic [3:0]   ID_VARIANT   = 4'h1,    // arbitrary value
   parameter logic [3:0]   ID_REVISION  = 4'h2,    // arbitrary value
   parameter logic [3:0]   ID_CONT      = 4'h5,    // arbitrary value
   parameter logic [6:0]   ID_CODE      = 7'h2a,   // arbitrary value
   parameter logic [127:0] EVENT_CAP    = 128'h3,
   parameter bit           MSI_IMPL     = 1'b1,
   parameter bit           WIRED_IMPL   = 1'b1
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   input  wire pcgc_pkg::pcgc_req_t   bus_req_in,
   output logic [31:0]                bus_rdata_out,
   output logic                       bus_rvalid_out,
   input  wire logic [NUM_CTR-1:0]    per_counter_enable_in,
   input  wire logic [NUM_CTR-1:0]    event_in,
   output logic [NUM_CTR-1:0]         count_inc_out,
   input  wire logic [NUM_CTR-1:0]    overflow_status_set_in,
   input  wire logic [NUM_CTR-1:0]    counter_overflow_irq_enable_in,
   input  wire pcgc_pkg::pcgc_msi_cfg_t msi_cfg_in,
   output pcgc_pkg::pcgc_msi_cfg_t    msi_cfg_out,
   output logic                       msi_cfg_guard_out,
   output logic                       msi_req_out,
   input  wire logic                  msi_done_in,
   output logic                       irq_edge_out
);
   logic                  global_en_r;
   logic                  irq_ctrl_r;
   pcgc_pkg::pcgc_state_t st_r;
   pcgc_pkg::pcgc_state_t st_nxt;
   logic                  ack;
   logic                  raise;
   logic                  wr;
   logic                  rd;
   logic [31:0]           rdata_nxt;
   logic [31:0]           id_word;
   logic                  msi_req_r;
   logic                  irq_edge_r;
   logic [NUM_CTR-1:0]    inc_r;
   pcgc_pkg::pcgc_msi_cfg_t msi_cfg_r;

   assign wr = bus_req_in.valid && bus_req_in.write;
   assign rd = bus_req_in.valid && !bus_req_in.write;

   // software writes to the two control words; other offsets ignore writes
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         global_en_r <= `PCGC_RST_BIT;
         irq_ctrl_r  <= `PCGC_RST_BIT;
      end else if (wr) begin
         if (bus_req_in.addr == `PCGC_OFF_COUNT_CTRL) begin
            global_en_r <= bus_req_in.wdata[`PCGC_BIT_ENABLE];
         end
         if (bus_req_in.addr == `PCGC_OFF_IRQ_CTRL) begin
            irq_ctrl_r <= bus_req_in.wdata[`PCGC_BIT_ENABLE];
         end
      end
   end

   // increments are gated by the global bit ahead of the per-counter enables
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         inc_r <= '0;
      end else begin
         inc_r <= (global_en_r ? per_counter_enable_in : '0) & event_in;
      end
   end
   assign count_inc_out = inc_r;

   // identity word; a zero word tells software nothing is identified
   always_comb begin
      id_word = '0;
      if (ID_IMPL) begin
         id_word[`PCGC_ID_PART_HI:`PCGC_ID_PART_LO] = ID_PART;
         id_word[`PCGC_ID_VAR_HI:`PCGC_ID_VAR_LO]   = ID_VARIANT;
         id_word[`PCGC_ID_REV_HI:`PCGC_ID_REV_LO]   = ID_REVISION;
         id_word[`PCGC_ID_CONT_HI:`PCGC_ID_CONT_LO] = ID_CONT;
         id_word[`PCGC_ID_ZERO_BIT]                 = 1'b0;
         id_word[`PCGC_ID_CODE_HI:`PCGC_ID_CODE_LO] = ID_CODE;
      end
   end

   // read mux; unmapped offsets read zero, reserved bits read zero
   always_comb begin
      rdata_nxt = '0;
      unique case (bus_req_in.addr)
         `PCGC_OFF_COUNT_CTRL:  rdata_nxt[`PCGC_BIT_ENABLE] = global_en_r;
         `PCGC_OFF_IDENTITY:    rdata_nxt = id_word;
         `PCGC_OFF_CAP_LOW_LO:  rdata_nxt = EVENT_CAP[31:0];
         `PCGC_OFF_CAP_LOW_HI:  rdata_nxt = EVENT_CAP[63:32];
         `PCGC_OFF_CAP_HIGH_LO: rdata_nxt = EVENT_CAP[95:64];
         `PCGC_OFF_CAP_HIGH_HI: rdata_nxt = EVENT_CAP[127:96];
         `PCGC_OFF_IRQ_CTRL:    rdata_nxt[`PCGC_BIT_ENABLE] = irq_ctrl_r;
         `PCGC_OFF_IRQ_ACK:     rdata_nxt[`PCGC_BIT_ENABLE] = ack;
         default:               rdata_nxt = '0;
      endcase
   end

   // read data answers one cycle after the request
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         bus_rdata_out  <= `PCGC_RST_WORD;
         bus_rvalid_out <= 1'b0;
      end else begin
         bus_rvalid_out <= rd;
         bus_rdata_out  <= rd ? rdata_nxt : `PCGC_RST_WORD;
      end
   end

   // enable update: the acknowledge shows the new value only once its side
   // effects are done, so software polling it sees a settled group
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         pcgc_pkg::PCGC_OFF: if (irq_ctrl_r) st_nxt = pcgc_pkg::PCGC_ENA;
         pcgc_pkg::PCGC_ENA: st_nxt = pcgc_pkg::PCGC_ON;
         pcgc_pkg::PCGC_ON:  if (!irq_ctrl_r) st_nxt = pcgc_pkg::PCGC_DIS;
         pcgc_pkg::PCGC_DIS: if (!msi_req_r) st_nxt = pcgc_pkg::PCGC_OFF;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= pcgc_pkg::PCGC_OFF;
      end else begin
         st_r <= st_nxt;
      end
   end
   // ack is high from completed enable until completed disable
   assign ack = (st_r == pcgc_pkg::PCGC_ON) || (st_r == pcgc_pkg::PCGC_DIS);

   // configuration is frozen while enabling so later messages use it
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         msi_cfg_r <= '0;
      end else if (st_r == pcgc_pkg::PCGC_ENA) begin
         msi_cfg_r <= msi_cfg_in;
      end
   end
   assign msi_cfg_out = msi_cfg_r;

   // config registers outside are read-only while either enable copy is set
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         msi_cfg_guard_out <= 1'b0;
      end else begin
         msi_cfg_guard_out <= irq_ctrl_r || st_nxt != pcgc_pkg::PCGC_OFF;
      end
   end

   // raise needs both the written enable and a completed enable update
   assign raise = irq_ctrl_r && (st_r == pcgc_pkg::PCGC_ON) &&
                  |(overflow_status_set_in & counter_overflow_irq_enable_in);

   // wired edge is raise registered one cycle late, high for as long as raise is
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_edge_r <= 1'b0;
      end else begin
         irq_edge_r <= raise && WIRED_IMPL;
      end
   end
   assign irq_edge_out = irq_edge_r;

   // one message outstanding at most; a new raise while pending merges
   // with it, and a set in the completion cycle wins over the clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         msi_req_r <= 1'b0;
      end else if (raise && MSI_IMPL && msi_cfg_r.addr != '0) begin
         msi_req_r <= 1'b1;
      end else if (msi_done_in) begin
         msi_req_r <= 1'b0;
      end
   end
   assign msi_req_out = msi_req_r;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_arm;
      $rose(irq_ctrl_r) && st_r == pcgc_pkg::PCGC_OFF;
   endsequence
   sequence s_acked;
      ##[1:3] ack;
   endsequence

   property p_no_count;
      !global_en_r |=> count_inc_out == '0;
   endproperty
   a_no_count: assert property (p_no_count) else $error("count while disabled");

   property p_override;
      (global_en_r && (per_counter_enable_in & event_in) != '0) |=> count_inc_out != '0;
   endproperty
   a_override: assert property (p_override) else $error("enabled event lost");

   property p_id_read;
      (rd && bus_req_in.addr == `PCGC_OFF_IDENTITY) |=>
         bus_rdata_out[`PCGC_ID_ZERO_BIT] == 1'b0 && (ID_IMPL || bus_rdata_out == '0);
   endproperty
   a_id_read: assert property (p_id_read) else $error("identity word wrong");

   property p_ctrl_res;
      (rd && bus_req_in.addr == `PCGC_OFF_IRQ_CTRL) |=> bus_rdata_out[31:1] == '0;
   endproperty
   a_ctrl_res: assert property (p_ctrl_res) else $error("control reserved bits set");

   property p_ack_res;
      (rd && bus_req_in.addr == `PCGC_OFF_IRQ_ACK) |=>
         bus_rdata_out[31:1] == '0 && bus_rdata_out[0] == $past(ack);
   endproperty
   a_ack_res: assert property (p_ack_res) else $error("ack word wrong");

   property p_quiet;
      !irq_ctrl_r |=> !irq_edge_out && !$rose(msi_req_out);
   endproperty
   a_quiet: assert property (p_quiet) else $error("interrupt while disabled");

   property p_cause;
      irq_edge_out |-> $past(raise) && $past(irq_ctrl_r);
   endproperty
   a_cause: assert property (p_cause) else $error("edge without cause");

   property p_ack_follow;
      s_arm |-> s_acked;
   endproperty
   a_ack_follow: assert property (p_ack_follow) else $error("enable not acknowledged");

   property p_cfg_fix;
      $rose(ack) |-> msi_cfg_out == $past(msi_cfg_in);
   endproperty
   a_cfg_fix: assert property (p_cfg_fix) else $error("config not captured");

   property p_drain;
      $fell(ack) |-> !msi_req_out ##1 (!irq_edge_out && !msi_req_out);
   endproperty
   a_drain: assert property (p_drain) else $error("disable before drain");

   // count control is a single bit; the rest of the word must never leak state
   property p_cnt_res;
      (rd && bus_req_in.addr == `PCGC_OFF_COUNT_CTRL) |=> bus_rdata_out[31:1] == '0;
   endproperty
   a_cnt_res: assert property (p_cnt_res) else $error("count control reserved bits set");

   // a write to count control lands at the taking edge
   property p_cnt_wr;
      (wr && bus_req_in.addr == `PCGC_OFF_COUNT_CTRL) |=>
         global_en_r == $past(bus_req_in.wdata[`PCGC_BIT_ENABLE]);
   endproperty
   a_cnt_wr: assert property (p_cnt_wr) else $error("count enable write lost");

   // a write to interrupt control lands at the taking edge
   property p_ctrl_wr;
      (wr && bus_req_in.addr == `PCGC_OFF_IRQ_CTRL) |=>
         irq_ctrl_r == $past(bus_req_in.wdata[`PCGC_BIT_ENABLE]);
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("interrupt enable write lost");

   // lowest capability word carries events 0 to 31 unchanged
   property p_cap_low;
      (rd && bus_req_in.addr == `PCGC_OFF_CAP_LOW_LO) |=> bus_rdata_out == EVENT_CAP[31:0];
   endproperty
   a_cap_low: assert property (p_cap_low) else $error("low capability word wrong");

   // top capability word carries the highest events unchanged
   property p_cap_high;
      (rd && bus_req_in.addr == `PCGC_OFF_CAP_HIGH_HI) |=> bus_rdata_out == EVENT_CAP[127:96];
   endproperty
   a_cap_high: assert property (p_cap_high) else $error("high capability word wrong");

   // an increment never appears on a counter whose own enable was clear
   property p_inc_sub;
      1'b1 |=> (count_inc_out & ~$past(per_counter_enable_in)) == '0;
   endproperty
   a_inc_sub: assert property (p_inc_sub) else $error("increment on disabled counter");

   // a wired edge only follows a completed enable update
   property p_gate;
      irq_edge_out |-> $past(ack);
   endproperty
   a_gate: assert property (p_gate) else $error("edge before enable acknowledged");

   // a new message request needs the written and the acknowledged enable
   property p_msi_cause;
      $rose(msi_req_out) |-> $past(ack) && $past(irq_ctrl_r);
   endproperty
   a_msi_cause: assert property (p_msi_cause) else $error("message without cause");

   // a pending message keeps the disable from being acknowledged
   property p_hold_dis;
      (st_r == pcgc_pkg::PCGC_DIS && msi_req_out) |=> ack;
   endproperty
   a_hold_dis: assert property (p_hold_dis) else $error("disable acked with message pending");

   // a message request stands until the interconnect reports completion
   property p_msi_hold;
      (msi_req_out && !msi_done_in) |=> msi_req_out;
   endproperty
   a_msi_hold: assert property (p_msi_hold) else $error("message request dropped early");

   // outside configuration is locked once software has set the enable
   property p_guard;
      irq_ctrl_r |=> msi_cfg_guard_out;
   endproperty
   a_guard: assert property (p_guard) else $error("config unguarded while enabled");

   // the captured configuration cannot drift while interrupts are live
   property p_cfg_stable;
      (st_r == pcgc_pkg::PCGC_ON) |=> $stable(msi_cfg_out);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("config changed while live");

   // part number field read back, or an all-zero word when not provided
   property p_id_part;
      (rd && bus_req_in.addr == `PCGC_OFF_IDENTITY) |=>
         (ID_IMPL ? bus_rdata_out[`PCGC_ID_PART_HI:`PCGC_ID_PART_LO] == ID_PART
                  : bus_rdata_out == '0);
   endproperty
   a_id_part: assert property (p_id_part) else $error("identity part field wrong");
endmodule // pcgc_regs
`default_nettype wire

/* File: hw/pcgc_map.svh */
`ifndef PCGC_MAP_SVH
`define PCGC_MAP_SVH
// register byte offsets inside the page
`define PCGC_OFF_COUNT_CTRL  12'he04
`define PCGC_OFF_IDENTITY    12'he08
`define PCGC_OFF_CAP_LOW_LO  12'he20
`define PCGC_OFF_CAP_LOW_HI  12'he24
`define PCGC_OFF_CAP_HIGH_LO 12'he28
`define PCGC_OFF_CAP_HIGH_HI 12'he2c
`define PCGC_OFF_IRQ_CTRL    12'he50
`define PCGC_OFF_IRQ_ACK     12'he54
// field positions
`define PCGC_BIT_ENABLE      0
`define PCGC_ID_PART_HI      31
`define PCGC_ID_PART_LO      20
`define PCGC_ID_VAR_HI       19
`define PCGC_ID_VAR_LO       16
`define PCGC_ID_REV_HI       15
`define PCGC_ID_REV_LO       12
`define PCGC_ID_CONT_HI      11
`define PCGC_ID_CONT_LO      8
`define PCGC_ID_ZERO_BIT     7
`define PCGC_ID_CODE_HI      6
`define PCGC_ID_CODE_LO      0
// reset values
`define PCGC_RST_BIT         1'h0
`define PCGC_RST_WORD        32'h0
`endif

/* File: hw/pcgc_pkg.sv */
package pcgc_pkg;
   // one register access, taken in the cycle that valid is high
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } pcgc_req_t;

   // message interrupt configuration
   typedef struct packed {
      logic [51:2] addr;
      logic [31:0] data;
      logic [5:0]  attr;
   } pcgc_msi_cfg_t;

   // enable update handshake, gray along off-enabling-on-disabling
   typedef enum logic [1:0] {
      PCGC_OFF = 2'h0,
      PCGC_ENA = 2'h1,
      PCGC_ON  = 2'h3,
      PCGC_DIS = 2'h2
   } pcgc_state_t;
endpackage

/* File: tb/pcgc_msi_sink.sv */
`timescale 1ns/100ps
`default_nettype none
// message write target: completes each request after a chosen number of cycles
module pcgc_msi_sink (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       msi_req_in,
   input  wire logic [3:0] delay_in,
   output logic            msi_done_out
);
   logic [3:0] wait_r;

   // one done pulse per request; the edge that sees done is skipped, since the
   // requester only drops its level at that same edge and must not be answered twice
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wait_r       <= 4'h0;
         msi_done_out <= 1'b0;
      end else if (msi_done_out) begin
         wait_r       <= 4'h0;
         msi_done_out <= 1'b0;
      end else if (msi_req_in) begin
         if (wait_r == delay_in) begin
            msi_done_out <= 1'b1;
         end else begin
            wait_r <= wait_r + 4'h1; // slow answers hold the disable handshake open
         end
      end
   end
endmodule // pcgc_msi_sink
`default_nettype wire

/* File: tb/test_perf_counter_group_ctrl_irq.sv */
`timescale 1ns/100ps
`default_nettype none
module test_perf_counter_group_ctrl_irq;
   typedef struct packed {logic [11:0] a; logic [31:0] d;} pcgc_row_t;
   // identity built from the design's arbitrary default fields
   localparam logic [31:0] ID_EXP = {12'h123, 4'h1, 4'h2, 4'h5, 1'b0, 7'h2a};
   localparam pcgc_pkg::pcgc_msi_cfg_t CFG_A = '{addr: 50'h1234, data: 32'hcafe0001, attr: 6'h15};
   logic                    clk_in, rst_in, rvalid, guard, req, done, edge_o;
   pcgc_pkg::pcgc_req_t     bus;
   pcgc_pkg::pcgc_msi_cfg_t cfg_in, cfg_out;
   logic [31:0]             rdata, got;
   logic [3:0]              per_en, ev, inc, ovf, ien, dly;
   int                      n_mismatch, tests_run;
   pcgc_row_t rows [9] = '{'{12'he04, 32'h0}, '{12'he08, ID_EXP}, '{12'he20, 32'h3},
      '{12'he24, 32'h0}, '{12'he28, 32'h0}, '{12'he2c, 32'h0}, '{12'he50, 32'h0},
      '{12'he54, 32'h0}, '{12'he30, 32'h0}};

   pcgc_regs u_dut (.clk_in(clk_in), .rst_in(rst_in), .bus_req_in(bus), .bus_rdata_out(rdata),
      .bus_rvalid_out(rvalid), .per_counter_enable_in(per_en), .event_in(ev),
      .count_inc_out(inc), .overflow_status_set_in(ovf), .counter_overflow_irq_enable_in(ien),
      .msi_cfg_in(cfg_in), .msi_cfg_out(cfg_out), .msi_cfg_guard_out(guard),
      .msi_req_out(req), .msi_done_in(done), .irq_edge_out(edge_o));
   pcgc_msi_sink u_sink (.clk_in(clk_in), .rst_in(rst_in), .msi_req_in(req), .delay_in(dly),
      .msi_done_out(done));

   // free-running 100 MHz clock
   always #5 clk_in = ~clk_in;

   task automatic conclude();
      $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [87:0] e, input logic [87:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   // one bus access; read data is picked up just after the taking edge
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      bus <= '{valid: 1'b1, write: w, addr: a, wdata: d};
      @(posedge clk_in);
      bus <= '0;
      #1;
      got = rdata;
      if (!w) chk("rvalid", 1'b1, rvalid);
   endtask

   // software waits for the acknowledge to follow the written enable, bounded
   task automatic poll(input logic e);
      for (int i = 0; i < 40; i++) begin
         acc(1'b0, 12'he54, 32'h0);
         if (got[0] === e) return;
      end
      n_mismatch++;
      $display("MISMATCH ack poll expected %h seen %h", e, got[0]);
      conclude();
   endtask

   // one overflow pulse, returning just after the edge that answers it
   task automatic raise(input logic [3:0] s);
      @(posedge clk_in);
      ovf <= s;
      @(posedge clk_in);
      ovf <= 4'h0;
      #1;
   endtask

   // hang guard
   initial begin
      #100000;
      n_mismatch++;
      conclude();
   end

   initial begin
      clk_in = 1'b0;
      rst_in = 1'b1;
      bus = '0;
      {per_en, ev, ovf, ien, dly} = '0;
      cfg_in = '0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      // reset values, identity, capability words and an unmapped place
      foreach (rows[i]) begin
         acc(1'b0, rows[i].a, 32'h0);
         chk("rdata", rows[i].d, got);
      end
      acc(1'b1, 12'he08, 32'hffff_ffff);
      acc(1'b1, 12'he20, 32'h0);
      acc(1'b0, 12'he08, 32'h0);
      chk("identity ro", ID_EXP, got);
      acc(1'b0, 12'he20, 32'h0);
      chk("capability ro", 32'h3, got);
      $display("test done: register map");
      // global count enable over per-counter enables
      @(posedge clk_in);
      per_en <= 4'hf;
      ev <= 4'hf;
      @(posedge clk_in);
      #1;
      chk("inc off", 4'h0, inc);
      acc(1'b1, 12'he04, 32'hffff_ffff);
      @(posedge clk_in);
      per_en <= 4'h5;
      @(posedge clk_in);
      #1;
      chk("inc on", 4'h5, inc);
      acc(1'b0, 12'he04, 32'h0);
      chk("count ctrl", 32'h1, got);
      ev <= 4'h0;
      $display("test done: counting");
      // overflow with the group enable clear stays silent
      @(posedge clk_in);
      ien <= 4'hf;
      cfg_in <= CFG_A;
      raise(4'hf);
      chk("edge off", 1'b0, edge_o);
      chk("req off", 1'b0, req);
      acc(1'b1, 12'he50, 32'hffff_ffff);
      poll(1'b1);
      acc(1'b0, 12'he50, 32'h0);
      chk("irq ctrl", 32'h1, got);
      acc(1'b0, 12'he54, 32'h0);
      chk("irq ack", 32'h1, got);
      chk("guard", 1'b1, guard);
      chk("cfg in use", CFG_A, cfg_out);
      @(posedge clk_in);
      ien <= 4'h2;
      raise(4'h1);
      chk("edge masked", 1'b0, edge_o);
      raise(4'h2);
      chk("edge", 1'b1, edge_o);
      chk("req", 1'b1, req);
      repeat (4) @(posedge clk_in);
      #1;
      chk("req done", 1'b0, req);
      $display("test done: interrupt raise");
      // disable while a slow message write is outstanding
      @(posedge clk_in);
      dly <= 4'hc;
      raise(4'h2);
      acc(1'b1, 12'he50, 32'h0);
      acc(1'b0, 12'he54, 32'h0);
      chk("ack held", 32'h1, got);
      poll(1'b0);
      chk("req at ack", 1'b0, req);
      chk("guard off", 1'b0, guard);
      raise(4'h2);
      chk("edge after", 1'b0, edge_o);
      chk("req after", 1'b0, req);
      $display("test done: disable");
      conclude();
   end
endmodule // test_perf_counter_group_ctrl_irq
`default_nettype wire
